// [design/sacf_pkg.sv]
// Shared constants and types for the servo axis configuration and fault policy block
package sacf_pkg;

	// Clock and scan timing
	localparam int CLK_KHZ = 250000;
	localparam int SCAN_FAST_MS = 2;
	localparam int SCAN_SLOW_MS = 10;
	localparam int SCAN_FAST_CYC = CLK_KHZ * SCAN_FAST_MS;
	localparam int SCAN_SLOW_CYC = CLK_KHZ * SCAN_SLOW_MS;

	// Register byte offsets, low address byte only
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_ZONE_ON = 8'h08;
	localparam logic [7:0] ADDR_ZONE_OFF = 8'h0C;
	localparam logic [7:0] ADDR_CMD_SCALE = 8'h10;
	localparam logic [7:0] ADDR_PULSE_SCALE = 8'h14;
	localparam logic [7:0] ADDR_VMAX = 8'h18;
	localparam logic [7:0] ADDR_FILTER = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_VLIMIT = 8'h24;
	localparam logic [7:0] ADDR_POSCMD = 8'h28;

	// Mode register bits
	localparam int MODE_SETUP = 0;
	localparam int MODE_SERVO_ON = 1;
	localparam int MODE_SERVO_OFF = 2;
	localparam int MODE_JOG_PLUS = 3;
	localparam int MODE_JOG_MINUS = 4;

	// Filter register fields
	localparam int BAND_W = 11;
	localparam int FILT_CMD_LSB = 16;

	// Legal value ranges
	localparam logic [31:0] SCALE_MIN = 32'h0000_03E8;
	localparam logic [31:0] SCALE_MAX = 32'h05F5_E0FF;
	localparam logic signed [31:0] ZONE_LIM = 32'sh3B9A_C9FF;
	localparam logic [31:0] VMAX_MIN = 32'h0000_0001;
	localparam logic [31:0] VMAX_MAX = 32'h00F4_2400;
	localparam logic [BAND_W-1:0] BAND_MIN = 11'h032;
	localparam logic [BAND_W-1:0] BAND_MAX = 11'h3E8;

	// Command units per turn (rotary) or per metre (linear)
	localparam logic [31:0] DEG_MILLI = 32'h0005_7E40;
	localparam logic [31:0] DEG_CENTI = 32'h0000_8CA0;
	localparam logic [31:0] DEG_TENTH = 32'h0036_EE80;
	localparam logic [31:0] LIN_UM1 = 32'h000F_4240;
	localparam logic [31:0] LIN_UM10 = 32'h0001_86A0;
	localparam logic [31:0] LIN_UM01 = 32'h0098_9680;

	typedef enum logic [2:0] {UNIT_PULSE, UNIT_MILLI, UNIT_CENTI, UNIT_SCALE, UNIT_TENTH}
		sacf_unit_type;
	typedef enum logic [1:0] {POL_KEEP, POL_OFF_AFTER, POL_OFF_NOW} sacf_policy_type;

	// Configuration word, laid out exactly as the config register low bits
	typedef struct packed {
		logic fbFilterUse;
		sacf_policy_type devPol;
		sacf_policy_type ovlPol;
		sacf_policy_type ovsPol;
		logic devEn;
		logic ovsEn;
		logic ovlEn;
		logic jogSource;
		logic powerupServo;
		logic fastScan;
		logic coordLinear;
		sacf_unit_type unit;
	} sacf_cfg_type;
	localparam int CFG_W = $bits(sacf_cfg_type);

	localparam sacf_cfg_type CFG_RST = '{fbFilterUse: 1'b0, devPol: POL_OFF_AFTER,
		ovlPol: POL_KEEP, ovsPol: POL_KEEP, devEn: 1'b1, ovsEn: 1'b1, ovlEn: 1'b1,
		jogSource: 1'b0, powerupServo: 1'b0, fastScan: 1'b0, coordLinear: 1'b0,
		unit: UNIT_PULSE};
	localparam logic [31:0] SCALE_RST = 32'h0000_03E8;
	localparam logic signed [31:0] ZONE_RST = 32'sh0000_0000;

	// Status word, laid out as the status register low bits
	typedef struct packed {
		logic reject;
		logic devFault;
		logic ovlFault;
		logic ovsFault;
		logic axisStop;
		logic servoOn;
		logic zone;
	} sacf_stat_type;
	localparam int STAT_W = $bits(sacf_stat_type);

	// One fault channel's answer
	typedef struct packed {
		logic latched;
		logic stopReq;
		logic servoOff;
	} sacf_fault_type;

endpackage : sacf_pkg

// [design/sacf_fault_policy.sv]
// One fault channel: enable gating, latch and three-way servo policy
module sacf_fault_policy
	import sacf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic enable,
	input wire sacf_policy_type policy,
	input wire logic condition,
	input wire logic axisStopped,
	input wire logic clear,
	output sacf_fault_type fault
);

	logic active_r;
	logic activeNxt;
	logic offNxt;
	sacf_fault_type fault_r;

	// A new event beats a clear in the same cycle
	assign activeNxt = (enable & condition) | (active_r & ~clear);
	assign offNxt = activeNxt & ((policy == POL_OFF_NOW) |
		((policy == POL_OFF_AFTER) & axisStopped)); // [RQ18] [RQ19] [RQ22]

	// Latch and registered answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			active_r <= 1'b0;
			fault_r <= '0;
		end else begin
			active_r <= activeNxt;
			fault_r <= '{latched: activeNxt, stopReq: activeNxt, servoOff: offNxt};
		end
	end

	assign fault = fault_r;

endmodule : sacf_fault_policy

// [design/sacf_serial_div.sv]
// Serial restoring divider, one quotient bit per cycle, saturating result
module sacf_serial_div (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [63:0] dividend,
	input wire logic [31:0] divisor,
	output logic done,
	output logic [31:0] quotient
);

	logic [63:0] quo_r;
	logic [32:0] rem_r;
	logic [31:0] den_r;
	logic [6:0] cnt_r;
	logic busy_r;
	logic done_r;
	logic [32:0] remShift;
	logic [32:0] remSub;
	logic fits;

	assign remShift = {rem_r[31:0], quo_r[63]};
	assign remSub = remShift - {1'b0, den_r};
	assign fits = remShift >= {1'b0, den_r};

	// Shift and subtract; busy for 64 cycles after start
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			quo_r <= '0;
			rem_r <= '0;
			den_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			quo_r <= dividend;
			rem_r <= '0;
			den_r <= divisor;
			cnt_r <= '0;
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end else if (busy_r) begin
			quo_r <= {quo_r[62:0], fits};
			rem_r <= fits ? remSub : remShift;
			cnt_r <= cnt_r + 7'h01;
			busy_r <= (cnt_r != 7'h3F);
			done_r <= (cnt_r == 7'h3F);
		end else begin
			done_r <= 1'b0;
		end
	end

	assign done = done_r;
	// Results beyond 31 bits clip rather than wrap
	assign quotient = (quo_r[63:31] != '0) ? 32'h7FFF_FFFF : quo_r[31:0];

endmodule : sacf_serial_div

// [design/sacf_axis_config.sv]
// Axis configuration and fault policy with AHB-Lite registers
//
// Notes on behaviour
// RQ1: Zone asserts at set on position
// RQ2: Zone releases at signed off position
// RQ3: Unit 0: pulse is command unit
// RQ4: Unit 1: millidegree or micron
// RQ5: Unit 2: centidegree or ten microns
// RQ6: Unit 3: command scale per pulse scale
// RQ7: Unit 4: decimillidegree or tenth micron
// RQ8: Command scale 1000 to 99999999
// RQ9: Pulse scale same range
// RQ10: Coordinate bit: rotary or linear
// RQ11: Velocity limit is lesser, reported
// RQ12: Start scan 10ms delayed, 2ms direct
// RQ13: Serial power-up servo state
// RQ14: Jog from board or serial
// RQ15: Over-load error when enabled
// RQ16: Over-speed error when enabled
// RQ17: Deviation error when enabled
// RQ18: Over-speed three-way policy
// RQ19: Over-load three-way policy
// RQ20: Filter bands 50 to 1000 Hz
// RQ21: Settings change in setup mode only
// RQ22: Deviation policy, default off after
// RQ23: Zone refreshed every control scan
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
module sacf_axis_config
	import sacf_pkg::*;
#(
	parameter int FAST_SCAN_CYCLES = SCAN_FAST_CYC,
	parameter int SLOW_SCAN_CYCLES = SCAN_SLOW_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic signed [31:0] axisPositionPulse,
	input wire logic [31:0] motorVmaxPulse,
	input wire logic overloadPin,
	input wire logic overspeedPin,
	input wire logic deviationPin,
	input wire logic axisStoppedPin,
	input wire logic startPin,
	input wire logic jogPlusPin,
	input wire logic jogMinusPin,
	input wire logic serialModePin,
	output logic zoneOne,
	output logic servoOn,
	output logic axisStop,
	output logic startRequest,
	output logic jogPlus,
	output logic jogMinus,
	output logic [31:0] velocityLimit,
	output logic feedbackFilterUse,
	output logic [BAND_W-1:0] feedbackBand,
	output logic [BAND_W-1:0] commandBand
);

	typedef enum logic [1:0] {CONV_IDLE, CONV_POS, CONV_VEL} sacf_conv_type;

	// Pin synchronisers: first stage feeds only the second
	logic [7:0] pinMeta_r;
	logic [7:0] pinSync_r;
	logic overload_s, overspeed_s, deviation_s, stopped_s;
	logic start_s, jogPlus_s, jogMinus_s, serialMode_s;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
		end else begin
			pinMeta_r <= {serialModePin, jogMinusPin, jogPlusPin, startPin,
				axisStoppedPin, deviationPin, overspeedPin, overloadPin};
			pinSync_r <= pinMeta_r;
		end
	end

	assign {serialMode_s, jogMinus_s, jogPlus_s, start_s,
		stopped_s, deviation_s, overspeed_s, overload_s} = pinSync_r;

	// Bus slave state
	logic wrPend_r, rdPend_r;
	logic [7:0] busAddr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic addrPhase;
	assign addrPhase = hsel & htrans[1] & hready;

	// Software-visible registers
	logic setup_r, jogPlusSer_r, jogMinusSer_r;
	sacf_cfg_type cfg_r;
	logic signed [31:0] zoneOn_r, zoneOff_r;
	logic [31:0] cmdScale_r, pulseScale_r, vmax_r;
	logic [BAND_W-1:0] fbBand_r, cmdBand_r;
	logic reject_r;

	// Write decode on the data phase
	logic wrMode, wrCfg, wrOn, wrOff, wrCmdSc, wrPlsSc, wrVmax, wrFilt, wrStat;
	assign wrMode = wrPend_r & (busAddr_r == ADDR_MODE);
	assign wrCfg = wrPend_r & (busAddr_r == ADDR_CONFIG);
	assign wrOn = wrPend_r & (busAddr_r == ADDR_ZONE_ON);
	assign wrOff = wrPend_r & (busAddr_r == ADDR_ZONE_OFF);
	assign wrCmdSc = wrPend_r & (busAddr_r == ADDR_CMD_SCALE);
	assign wrPlsSc = wrPend_r & (busAddr_r == ADDR_PULSE_SCALE);
	assign wrVmax = wrPend_r & (busAddr_r == ADDR_VMAX);
	assign wrFilt = wrPend_r & (busAddr_r == ADDR_FILTER);
	assign wrStat = wrPend_r & (busAddr_r == ADDR_STATUS);

	// Value checks; out-of-range writes keep the old value
	sacf_cfg_type cfgIn;
	logic signed [31:0] wdSigned;
	logic [BAND_W-1:0] fbIn, cmdIn;
	logic cfgOk, onOk, offOk, cmdScOk, plsScOk, vmaxOk, filtOk;
	assign cfgIn = sacf_cfg_type'(hwdata[CFG_W-1:0]);
	assign wdSigned = $signed(hwdata);
	assign fbIn = hwdata[BAND_W-1:0];
	assign cmdIn = hwdata[FILT_CMD_LSB +: BAND_W];
	assign cfgOk = setup_r & (cfgIn.unit <= UNIT_TENTH) & (cfgIn.ovsPol <= POL_OFF_NOW)
		& (cfgIn.ovlPol <= POL_OFF_NOW) & (cfgIn.devPol <= POL_OFF_NOW); // [RQ21]
	assign onOk = cfg_r.coordLinear ? ((wdSigned >= -ZONE_LIM) & (wdSigned <= ZONE_LIM))
		: ((wdSigned >= 0) & (hwdata < cmdScale_r)); // [RQ1]
	assign offOk = (wdSigned >= -ZONE_LIM) & (wdSigned <= ZONE_LIM); // [RQ2]
	assign cmdScOk = setup_r & (hwdata >= SCALE_MIN) & (hwdata <= SCALE_MAX); // [RQ8]
	assign plsScOk = setup_r & (hwdata >= SCALE_MIN) & (hwdata <= SCALE_MAX); // [RQ9]
	assign vmaxOk = setup_r & (hwdata >= VMAX_MIN) & (hwdata <= VMAX_MAX);
	assign filtOk = setup_r & (fbIn >= BAND_MIN) & (fbIn <= BAND_MAX)
		& (cmdIn >= BAND_MIN) & (cmdIn <= BAND_MAX); // [RQ20]

	logic rejectEvt;
	assign rejectEvt = (wrCfg & ~cfgOk) | (wrOn & ~onOk) | (wrOff & ~offOk)
		| (wrCmdSc & ~cmdScOk) | (wrPlsSc & ~plsScOk) | (wrVmax & ~vmaxOk)
		| (wrFilt & ~filtOk);

	// Bus handshake: writes land with no wait, reads take one wait state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wrPend_r <= 1'b0;
			rdPend_r <= 1'b0;
			busAddr_r <= '0;
			hreadyout_r <= 1'b1;
		end else begin
			wrPend_r <= addrPhase & hwrite;
			rdPend_r <= addrPhase & ~hwrite;
			hreadyout_r <= ~(addrPhase & ~hwrite);
			if (addrPhase) begin
				busAddr_r <= {haddr[7:2], 2'b00};
			end
		end
	end

	// Mode register: setup flag and serial jog levels
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			setup_r <= 1'b0;
			jogPlusSer_r <= 1'b0;
			jogMinusSer_r <= 1'b0;
		end else if (wrMode) begin
			setup_r <= hwdata[MODE_SETUP];
			jogPlusSer_r <= hwdata[MODE_JOG_PLUS];
			jogMinusSer_r <= hwdata[MODE_JOG_MINUS];
		end
	end

	// Settings guarded by setup mode; zone positions writable any time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_r <= CFG_RST;
			zoneOn_r <= ZONE_RST;
			zoneOff_r <= ZONE_RST;
			cmdScale_r <= SCALE_RST;
			pulseScale_r <= SCALE_RST;
			vmax_r <= VMAX_MAX;
			fbBand_r <= BAND_MAX;
			cmdBand_r <= BAND_MAX;
		end else begin
			if (wrCfg & cfgOk) cfg_r <= cfgIn;
			if (wrOn & onOk) zoneOn_r <= wdSigned;
			if (wrOff & offOk) zoneOff_r <= wdSigned;
			if (wrCmdSc & cmdScOk) cmdScale_r <= hwdata;
			if (wrPlsSc & plsScOk) pulseScale_r <= hwdata;
			if (wrVmax & vmaxOk) vmax_r <= hwdata;
			if (wrFilt & filtOk) begin
				fbBand_r <= fbIn;
				cmdBand_r <= cmdIn;
			end
		end
	end

	// Status clear mask; the reject flag sets over a clear
	sacf_stat_type clrMask;
	assign clrMask = wrStat ? sacf_stat_type'(hwdata[STAT_W-1:0]) : '0;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reject_r <= 1'b0;
		end else begin
			reject_r <= rejectEvt | (reject_r & ~clrMask.reject);
		end
	end

	// Fault channels
	sacf_fault_type ovsFault, ovlFault, devFault;

	sacf_fault_policy uOverspeed (
		.clock(clock),
		.rst_n(rst_n),
		.enable(cfg_r.ovsEn), // [RQ16]
		.policy(cfg_r.ovsPol), // [RQ18]
		.condition(overspeed_s),
		.axisStopped(stopped_s),
		.clear(clrMask.ovsFault),
		.fault(ovsFault)
	);

	sacf_fault_policy uOverload (
		.clock(clock),
		.rst_n(rst_n),
		.enable(cfg_r.ovlEn), // [RQ15]
		.policy(cfg_r.ovlPol), // [RQ19]
		.condition(overload_s),
		.axisStopped(stopped_s),
		.clear(clrMask.ovlFault),
		.fault(ovlFault)
	);

	sacf_fault_policy uDeviation (
		.clock(clock),
		.rst_n(rst_n),
		.enable(cfg_r.devEn), // [RQ17]
		.policy(cfg_r.devPol), // [RQ22]
		.condition(deviation_s),
		.axisStopped(stopped_s),
		.clear(clrMask.devFault),
		.fault(devFault)
	);

	logic anyStop, anyOff;
	assign anyStop = ovsFault.stopReq | ovlFault.stopReq | devFault.stopReq;
	assign anyOff = ovsFault.servoOff | ovlFault.servoOff | devFault.servoOff;

	// Control scan and start scan dividers
	logic [31:0] scanCnt_r, startCnt_r;
	logic controlTick, startTick;
	logic [31:0] startPeriod;
	assign controlTick = (scanCnt_r == 32'(FAST_SCAN_CYCLES - 1));
	assign startPeriod = cfg_r.fastScan ? 32'(FAST_SCAN_CYCLES) : 32'(SLOW_SCAN_CYCLES); // [RQ12]
	assign startTick = (startCnt_r >= startPeriod - 32'h1);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			scanCnt_r <= '0;
			startCnt_r <= '0;
		end else begin
			scanCnt_r <= controlTick ? '0 : scanCnt_r + 32'h1;
			startCnt_r <= startTick ? '0 : startCnt_r + 32'h1;
		end
	end

	// Start sampling: slow mode needs two agreeing samples (delayed read)
	logic startPrev_r, startLevel_r, startReq_r;
	logic startAccept;
	assign startAccept = start_s & (cfg_r.fastScan | startPrev_r); // [RQ12]

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			startPrev_r <= 1'b0;
			startLevel_r <= 1'b0;
			startReq_r <= 1'b0;
		end else begin
			startReq_r <= startTick & startAccept & ~startLevel_r & ~cfg_r.jogSource;
			if (startTick) begin
				startPrev_r <= start_s;
				startLevel_r <= startAccept;
			end
		end
	end

	// Servo state: fault turn-off wins, then commands and power-up
	logic servoOn_r, firstScan_r, axisStop_r;
	logic powerupOn;
	assign powerupOn = firstScan_r & controlTick & serialMode_s & cfg_r.powerupServo; // [RQ13]

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			servoOn_r <= 1'b0;
			firstScan_r <= 1'b1;
			axisStop_r <= 1'b0;
		end else begin
			axisStop_r <= anyStop;
			if (controlTick) firstScan_r <= 1'b0;
			if (anyOff) begin
				servoOn_r <= 1'b0;
			end else if ((wrMode & hwdata[MODE_SERVO_ON]) | powerupOn) begin
				servoOn_r <= 1'b1;
			end else if (wrMode & hwdata[MODE_SERVO_OFF]) begin
				servoOn_r <= 1'b0;
			end
		end
	end

	// Jog source selection, blocked while stopping on a fault
	logic jogPlus_r, jogMinus_r;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			jogPlus_r <= 1'b0;
			jogMinus_r <= 1'b0;
		end else begin
			jogPlus_r <= ~anyStop & (cfg_r.jogSource ? jogPlusSer_r : jogPlus_s); // [RQ14]
			jogMinus_r <= ~anyStop & (cfg_r.jogSource ? jogMinusSer_r : jogMinus_s); // [RQ14]
		end
	end

	// Unit ratio: command units = pulses * num / den
	logic [31:0] ratioNum, ratioDen;
	logic lin;
	assign lin = cfg_r.coordLinear; // [RQ10]
	assign ratioNum = (cfg_r.unit == UNIT_MILLI) ? (lin ? LIN_UM1 : DEG_MILLI) // [RQ4]
		: (cfg_r.unit == UNIT_CENTI) ? (lin ? LIN_UM10 : DEG_CENTI) // [RQ5]
		: (cfg_r.unit == UNIT_SCALE) ? cmdScale_r // [RQ6]
		: (cfg_r.unit == UNIT_TENTH) ? (lin ? LIN_UM01 : DEG_TENTH) // [RQ7]
		: 32'h1; // [RQ3]
	assign ratioDen = (cfg_r.unit == UNIT_PULSE) ? 32'h1 : pulseScale_r; // [RQ3] [RQ9]

	// Conversion sequencer: position then velocity, once per control scan
	sacf_conv_type conv_r;
	logic divStart_r, posNeg_r;
	logic signed [31:0] posCmd_r;
	logic [31:0] vlimit_r;
	logic [31:0] posMag, divIn, quotient;
	logic [63:0] dividend;
	logic divDone;
	assign posMag = axisPositionPulse[31] ? 32'(-axisPositionPulse) : axisPositionPulse;
	assign divIn = (conv_r == CONV_POS) ? posMag : motorVmaxPulse;
	assign dividend = {32'h0, divIn} * {32'h0, ratioNum};

	sacf_serial_div uDiv (
		.clock(clock),
		.rst_n(rst_n),
		.start(divStart_r),
		.dividend(dividend),
		.divisor(ratioDen),
		.done(divDone),
		.quotient(quotient)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conv_r <= CONV_IDLE;
			divStart_r <= 1'b0;
			posNeg_r <= 1'b0;
			posCmd_r <= '0;
			vlimit_r <= VMAX_MAX;
		end else begin
			divStart_r <= 1'b0;
			case (conv_r)
				CONV_IDLE: begin
					if (controlTick) begin
						conv_r <= CONV_POS;
						divStart_r <= 1'b1;
						posNeg_r <= axisPositionPulse[31];
					end
				end
				CONV_POS: begin
					if (divDone) begin
						posCmd_r <= posNeg_r ? -$signed(quotient) : $signed(quotient);
						conv_r <= CONV_VEL;
						divStart_r <= 1'b1;
					end
				end
				CONV_VEL: begin
					if (divDone) begin
						vlimit_r <= (quotient < vmax_r) ? quotient : vmax_r; // [RQ11]
						conv_r <= CONV_IDLE;
					end
				end
				default: begin
					conv_r <= CONV_IDLE;
				end
			endcase
		end
	end

	// Zone window; an on point above the off point wraps through zero
	logic zoneIn, zone_r, posDone;
	assign posDone = (conv_r == CONV_POS) & divDone;
	assign zoneIn = (zoneOn_r <= zoneOff_r)
		? ((posCmd_r >= zoneOn_r) & (posCmd_r < zoneOff_r))
		: ((posCmd_r >= zoneOn_r) | (posCmd_r < zoneOff_r)); // [RQ1] [RQ2]

	// Refreshed once per scan, after the fresh position is in
	logic zonePend_r;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			zone_r <= 1'b0;
			zonePend_r <= 1'b0;
		end else begin
			zonePend_r <= posDone;
			if (zonePend_r) zone_r <= zoneIn; // [RQ23]
		end
	end

	// Read mux, sampled in the wait cycle so earlier writes are seen
	sacf_stat_type stat;
	logic [31:0] rdMux;
	assign stat = '{reject: reject_r, devFault: devFault.latched,
		ovlFault: ovlFault.latched, ovsFault: ovsFault.latched,
		axisStop: axisStop_r, servoOn: servoOn_r, zone: zone_r};
	assign rdMux = (busAddr_r == ADDR_MODE) ? {27'h0, jogMinusSer_r, jogPlusSer_r, 2'b00, setup_r}
		: (busAddr_r == ADDR_CONFIG) ? {{(32-CFG_W){1'b0}}, cfg_r}
		: (busAddr_r == ADDR_ZONE_ON) ? zoneOn_r
		: (busAddr_r == ADDR_ZONE_OFF) ? zoneOff_r
		: (busAddr_r == ADDR_CMD_SCALE) ? cmdScale_r
		: (busAddr_r == ADDR_PULSE_SCALE) ? pulseScale_r
		: (busAddr_r == ADDR_VMAX) ? vmax_r
		: (busAddr_r == ADDR_FILTER) ? {5'h0, cmdBand_r, 5'h0, fbBand_r}
		: (busAddr_r == ADDR_STATUS) ? {{(32-STAT_W){1'b0}}, stat}
		: (busAddr_r == ADDR_VLIMIT) ? vlimit_r // [RQ11]
		: (busAddr_r == ADDR_POSCMD) ? posCmd_r
		: 32'h0;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hrdata_r <= '0;
		end else if (rdPend_r) begin
			hrdata_r <= rdMux;
		end
	end

	// Outputs straight from flops
	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0 & hreadyout_r;
	assign zoneOne = zone_r;
	assign servoOn = servoOn_r;
	assign axisStop = axisStop_r;
	assign startRequest = startReq_r;
	assign jogPlus = jogPlus_r;
	assign jogMinus = jogMinus_r;
	assign velocityLimit = vlimit_r;
	assign feedbackFilterUse = cfg_r.fbFilterUse;
	assign feedbackBand = fbBand_r;
	assign commandBand = cmdBand_r;

endmodule : sacf_axis_config

// [verification/sacf_motor_model.sv]
// Behavioural power stage and encoder facing the axis block
module sacf_motor_model #(
	parameter int STOP_DELAY = 30
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic axisStop,
	input wire logic [2:0] faultReq,
	input wire logic signed [31:0] posReq,
	output logic signed [31:0] axisPositionPulse,
	output logic [31:0] motorVmaxPulse,
	output logic [2:0] faultPins,
	output logic axisStoppedPin
);
	timeunit 1ns;
	timeprecision 1ps;
	int coast;
	// Encoder echoes bench position; drive limit 500000 pulses/s
	assign axisPositionPulse = posReq;
	assign motorVmaxPulse = 32'h0007_A120;
	assign faultPins = faultReq;
	// Axis coasts down before standstill, so servo-off-after-stop is seen late
	always_ff @(posedge clock) begin
		if (!rst_n || !axisStop) coast <= 0;
		else if (coast < STOP_DELAY) coast <= coast + 1;
	end
	assign axisStoppedPin = (coast == STOP_DELAY);
endmodule : sacf_motor_model

// [verification/sacf_axis_config_sva.sv]
// Port checks for the axis configuration block
module sacf_axis_config_sva
	import sacf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hwrite,
	input wire logic overloadPin,
	input wire logic overspeedPin,
	input wire logic deviationPin,
	input wire logic axisStop,
	input wire logic startRequest,
	input wire logic jogPlus,
	input wire logic jogMinus,
	input wire logic [31:0] velocityLimit,
	input wire logic feedbackFilterUse,
	input wire logic [BAND_W-1:0] feedbackBand,
	input wire logic [BAND_W-1:0] commandBand
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Start request, then a quiet stretch
	sequence startPulse_s;
		startRequest ##1 !startRequest [*8];
	endsequence
	start_pulse_a: assert property (startRequest |-> startPulse_s)
		else $error("start request not a lone pulse");
	vlim_ceiling_a: assert property (velocityLimit <= VMAX_MAX)
		else $error("velocity limit above ceiling");
	fb_band_a: assert property (feedbackBand inside {[BAND_MIN:BAND_MAX]})
		else $error("feedback band out of range");
	cmd_band_a: assert property (commandBand inside {[BAND_MIN:BAND_MAX]})
		else $error("command band out of range");
	jog_blocked_a: assert property (axisStop [*2] |-> !jogPlus && !jogMinus)
		else $error("jog passed while stopped");
	stop_cause_a: assert property ($rose(axisStop) |->
		$past(overloadPin || overspeedPin || deviationPin, 4)) else $error("stop without fault");
	stop_clear_a: assert property ($fell(axisStop) |->
		$past(hwrite) || $past(hwrite, 2) || $past(hwrite, 3)) else $error("stop dropped alone");
	filter_write_a: assert property ($changed(feedbackFilterUse) |->
		$past(hwrite) || $past(hwrite, 2) || $past(hwrite, 3)) else $error("filter use moved");
endmodule : sacf_axis_config_sva

bind sacf_axis_config sacf_axis_config_sva u_sacf_axis_config_sva (.*);

// [verification/tb_top.sv]
// Self-checking bench for the axis configuration block
module tb_top
	import sacf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, startPin = 1'h0;
	logic jogPlusPin = 1'h0, jogMinusPin = 1'h0, serialModePin = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, motorVmaxPulse, velocityLimit;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, faultReq = 3'h0, faultPins;
	logic signed [31:0] posReq = 32'sh0, axisPositionPulse;
	logic hreadyout, hresp, zoneOne, servoOn, axisStop, axisStoppedPin, startRequest;
	logic jogPlus, jogMinus, feedbackFilterUse;
	logic [BAND_W-1:0] feedbackBand, commandBand;
	int errors = 0, total_checks = 0;
	int polSh [3] = '{12, 10, 14};
	logic [7:0] tA [16] = '{ADDR_MODE, ADDR_CONFIG, ADDR_ZONE_ON, ADDR_ZONE_OFF, ADDR_CMD_SCALE,
		ADDR_PULSE_SCALE, ADDR_VMAX, ADDR_FILTER, ADDR_CMD_SCALE, ADDR_CMD_SCALE, ADDR_PULSE_SCALE,
		ADDR_VMAX, ADDR_FILTER, ADDR_FILTER, ADDR_ZONE_OFF, ADDR_ZONE_OFF};
	logic [31:0] tW [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 32'h3E7, 32'h05F5_E0FF, 32'h05F5_E100,
		32'h0, 32'h03E8_0031, 32'h0032_0032, 32'h3B9A_CA00, 32'hC465_3601};
	logic [31:0] tE [16] = '{0, 32'h4380, ZONE_RST, ZONE_RST, SCALE_RST, SCALE_RST, VMAX_MAX,
		32'h03E8_03E8, SCALE_MIN, SCALE_MAX, SCALE_MIN, VMAX_MAX, 32'h03E8_03E8,
		32'h0032_0032, 32'h0, 32'hC465_3601};
	logic [31:0] zOn [6] = '{32'h64, 32'h64, 32'h64, 32'h64, 32'hC8, 32'hC8};
	logic [31:0] zOff [6] = '{32'hC8, 32'hC8, 32'hC8, 32'hC8, 32'h64, 32'h64};
	logic [31:0] zPos [6] = '{32'h96, 32'hC8, 32'h63, 32'h64, 32'hFA, 32'h96};
	logic [3:0] uCfg [9] = '{0, 1, 2, 3, 4, 9, 10, 12, 8};
	logic [31:0] uExp [9] = '{32'hE10, 32'hE10, 32'h168, 32'hA, 32'h8CA0, 32'h2710, 32'h3E8,
		32'h186A0, 32'hE10};

	// 250 MHz clock
	always #2 clock = ~clock;

	sacf_axis_config #(.FAST_SCAN_CYCLES(200), .SLOW_SCAN_CYCLES(1000)) u_sacf_axis_config (
		.*, .hready(hreadyout), .overloadPin(faultPins[0]), .overspeedPin(faultPins[1]),
		.deviationPin(faultPins[2]));
	sacf_motor_model u_sacf_motor_model (.*);

	task automatic wrap_up;
		if (errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// Counted four-state compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// Bounded wait for ready
	task automatic waitRdy;
		int n;
		n = 0;
		@(posedge clock);
		while (hreadyout !== 1'h1) begin
			n++;
			if (n > 20) begin
				chk(32'h0, 32'h1);
				wrap_up();
			end
			@(posedge clock);
		end
	endtask : waitRdy

	// One word: address phase, data phase; read data to rd
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		waitRdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
	endtask : xfer

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(rd, e);
	endtask : rdChk

	// Main sequence
	initial begin
		int hits;
		repeat (8) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		for (int i = 0; i < 8; i++) rdChk(tA[i], tE[i]);
		xfer(1'h1, ADDR_CONFIG, 32'h0001_0000);
		rdChk(ADDR_CONFIG, 32'h4380);
		rdChk(ADDR_STATUS, 32'h40);
		rdChk(8'h80, 32'h0);
		xfer(1'h1, ADDR_MODE, 32'h1);
		for (int i = 8; i < 16; i++) begin
			xfer(1'h1, tA[i], tW[i]);
			rdChk(tA[i], tE[i]);
		end
		for (int i = 0; i < 6; i++) begin
			xfer(1'h1, ADDR_ZONE_ON, zOn[i]);
			xfer(1'h1, ADDR_ZONE_OFF, zOff[i]);
			posReq <= zPos[i];
			cyc(500);
			chk(zoneOne, 32'(i == 0 || i == 3 || i == 4));
		end
		xfer(1'h1, ADDR_PULSE_SCALE, 32'h0005_7E40);
		xfer(1'h1, ADDR_CMD_SCALE, 32'h3E8);
		posReq <= 32'shE10;
		for (int i = 0; i < 9; i++) begin
			xfer(1'h1, ADDR_CONFIG, 32'h0001_4380 | uCfg[i]);
			cyc(500);
			rdChk(ADDR_POSCMD, uExp[i]);
		end
		xfer(1'h1, ADDR_CONFIG, 32'h0001_4380);
		xfer(1'h1, ADDR_VMAX, 32'h0006_1A80);
		cyc(500);
		chk(velocityLimit, 32'h0006_1A80);
		xfer(1'h1, ADDR_VMAX, VMAX_MAX);
		cyc(500);
		chk(velocityLimit, 32'h0007_A120);
		chk({feedbackFilterUse, feedbackBand}, 32'h832);
		// Each fault channel per policy; p == 3 disabled
		for (int ch = 0; ch < 3; ch++) begin
			for (int p = 0; p < 4; p++) begin
				xfer(1'h1, ADDR_CONFIG, 32'h0001_0000 | (p < 3 ? (32'h80 << ch) | (p << polSh[ch]) : 0));
				xfer(1'h1, ADDR_MODE, 32'h3);
				cyc(4);
				faultReq <= 3'h1 << ch;
				cyc(10);
				chk(axisStop, 32'(p < 3));
				chk(servoOn, 32'(p != 2));
				cyc(40);
				chk(servoOn, 32'(p == 0 || p == 3));
				faultReq <= 3'h0;
				cyc(4);
				xfer(1'h1, ADDR_STATUS, 32'h78);
				cyc(4);
			end
		end
		// Slow scan needs two samples, fast one
		for (int f = 0; f < 2; f++) begin
			xfer(1'h1, ADDR_CONFIG, 32'h0001_4380 | (f << 4));
			hits = 0;
			for (int i = 0; i < 320; i++) begin
				startPin <= (i < 300);
				@(posedge clock);
				hits += startRequest;
			end
			chk(hits, f);
		end
		jogPlusPin <= 1'h1;
		cyc(6);
		chk(jogPlus, 32'h1);
		xfer(1'h1, ADDR_CONFIG, 32'h0001_43C0);
		cyc(6);
		chk(jogPlus, 32'h0);
		xfer(1'h1, ADDR_MODE, 32'h9);
		cyc(6);
		chk(jogPlus, 32'h1);
		// Reset again in serial mode; power-up servo set before first tick
		rst_n <= 1'h0;
		serialModePin <= 1'h1;
		cyc(2);
		rst_n <= 1'h1;
		@(posedge clock);
		xfer(1'h1, ADDR_MODE, 32'h1);
		xfer(1'h1, ADDR_CONFIG, 32'h0000_43A0);
		cyc(300);
		chk(servoOn, 32'h1);
		wrap_up();
	end
endmodule : tb_top
